// ---- design/hsc_pkg.sv ----
// Purpose: shared constants and types of the start/done handshake block
// Assumes: one clock, synchronous active-high reset
// Notes: the control variant and result port are chosen by parameter
//
// Summary of operation
// R1: idle until launch request sampled high
// R2: quiescent flag drops when transaction begins
// R3: controller holds launch request until accept-next
// R4: request high at accept-next starts next
// R5: request low at accept-next: finish, halt
// R6: finish flag rises at operation end
// R7: result valid whenever finish flag high
// R8: accept-next inactive until a transaction started
// R9: accept-next asserted with finish flag
// R10: pipelined accept-next may come any later cycle
// R11: halting: quiescent high one cycle after finish
// R12: continuing: quiescent stays low
// R13: no-handshake variant has no control ports
// R14: result port only when function returns value
// R15: consumer drives proceed high when it accepts
// R16: proceed high at finish: keep operating
// R17: proceed low at finish: stop, hold finish, result
// R18: downstream accept-next may drive upstream proceed
// R19: producer times or holds unqualified input data
// R20: consumer samples unqualified output at right time
// R21: steady config held during operation
// R22: steady config fanout need not be registered
// R23: after reset quiescent high, others low
package hsc_pkg;

  // control variants
  localparam logic [1:0] HSC_MODE_NONE = 2'h0;
  localparam logic [1:0] HSC_MODE_BASIC = 2'h1;
  localparam logic [1:0] HSC_MODE_CHAIN = 2'h2;

  // defaults
  localparam int HSC_DATA_W_DEF = 16;
  localparam int HSC_LATENCY_DEF = 4;

  // values after reset
  localparam logic HSC_IDLE_RST = 1'b1;
  localparam logic HSC_DONE_RST = 1'b0;
  localparam logic HSC_READY_RST = 1'b0;
  localparam logic HSC_PEND_RST = 1'b0;

  typedef enum logic [1:0] {
    HSC_ST_IDLE,
    HSC_ST_RUN,
    HSC_ST_FIN
  } hsc_state_t;

endpackage

// ---- design/hsc_accum.sv ----
// Purpose: multi-cycle datapath, result = config + steps * operand
// Assumes: load and step never in the same cycle
// Notes: the config input is read without a register stage
`timescale 1ns/1ps
module hsc_accum #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // control
  input wire logic i_load,
  input wire logic i_step,
  // data
  input wire logic [DATA_W-1:0] i_operand,
  input wire logic [DATA_W-1:0] i_config,
  output logic [DATA_W-1:0] o_sum
);

  logic [DATA_W-1:0] acc_reg;
  logic [DATA_W-1:0] acc_next;
  logic [DATA_W-1:0] opnd_reg;
  logic [DATA_W-1:0] opnd_next;

  // operand captured at launch, so the producer need only present it then
  assign opnd_next = i_load ? i_operand : opnd_reg;
  assign acc_next = i_load ? i_config : (i_step ? o_sum : acc_reg); // R22
  assign o_sum = acc_reg + opnd_reg;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      acc_reg <= '0;
      opnd_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      opnd_reg <= opnd_next;
    end
  end

endmodule // hsc_accum

// ---- design/hsc_block.sv ----
// Purpose: block-level start/idle/ready/done handshake around a datapath
// Assumes: start, continue and data come from logic on the same clock
// Notes: non-pipelined; ports of an absent variant are held low
`timescale 1ns/1ps
module hsc_block
  import hsc_pkg::*;
#(
  parameter logic [1:0] CTRL_MODE = HSC_MODE_BASIC,
  parameter bit HAS_RESULT = 1'b1,
  parameter int DATA_W = HSC_DATA_W_DEF,
  parameter int LATENCY = HSC_LATENCY_DEF
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  // block handshake
  input wire logic I_LAUNCH_REQUEST,
  input wire logic I_DOWNSTREAM_PROCEED,
  output logic O_QUIESCENT_FLAG,
  output logic O_ACCEPT_NEXT_FLAG,
  output logic O_FINISH_FLAG,
  // data
  input wire logic [DATA_W-1:0] I_OPERAND,
  input wire logic [DATA_W-1:0] I_STEADY_CONFIG,
  output logic [DATA_W-1:0] O_RESULT_VALUE
);

  localparam int CNT_W = $clog2(LATENCY + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LATENCY - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

  generate
    if (LATENCY < 1 || CTRL_MODE > HSC_MODE_CHAIN || DATA_W < 1) begin : g_chk
      $error("hsc_block: unsupported parameter values");
    end
  endgenerate

  hsc_state_t state_reg;
  hsc_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic pend_reg;
  logic pend_next;
  logic idle_reg;
  logic idle_next;
  logic ready_reg;
  logic ready_next;
  logic done_reg;
  logic done_next;
  logic [DATA_W-1:0] result_reg;
  logic [DATA_W-1:0] result_next;

  wire logic no_hs = (CTRL_MODE == HSC_MODE_NONE);
  wire logic chain = (CTRL_MODE == HSC_MODE_CHAIN);
  // without control ports the block runs back to back on its own
  wire logic start_in = no_hs | I_LAUNCH_REQUEST; // R13
  wire logic go = ~chain | I_DOWNSTREAM_PROCEED; // R16
  wire logic in_idle = (state_reg == HSC_ST_IDLE);
  wire logic in_run = (state_reg == HSC_ST_RUN);
  wire logic in_fin = (state_reg == HSC_ST_FIN);
  wire logic run_last = in_run && (cnt_reg == CNT_LAST);
  // request seen in the accept-next cycle, or remembered while held
  // without control ports a finish always chains straight into a new run
  wire logic again = no_hs | (ready_reg ? start_in : pend_reg); // R4 R5
  wire logic launch = (in_idle && start_in) || (in_fin && go && again); // R1
  wire logic [DATA_W-1:0] sum;

  hsc_accum #(
    .DATA_W(DATA_W)
  ) u_accum (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_load(launch),
    .i_step(in_run),
    .i_operand(I_OPERAND),
    .i_config(I_STEADY_CONFIG),
    .o_sum(sum)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HSC_ST_IDLE: begin
        if (start_in) begin
          state_next = HSC_ST_RUN; // R1
        end
      end
      HSC_ST_RUN: begin
        if (run_last) begin
          state_next = HSC_ST_FIN; // R6
        end
      end
      HSC_ST_FIN: begin
        if (go && again) begin
          state_next = HSC_ST_RUN; // R4
        end else if (go) begin
          state_next = HSC_ST_IDLE; // R5
        end
      end
      default: begin
        state_next = HSC_ST_IDLE;
      end
    endcase
  end

  assign cnt_next = launch ? CNT_ZERO : (in_run ? cnt_reg + 1'b1 : cnt_reg);
  assign pend_next = in_fin ? again : HSC_PEND_RST;
  // idle and finish are registered from the next state, accept-next from the last run cycle, so each output is a flop
  assign idle_next = ~no_hs && (state_next == HSC_ST_IDLE); // R2 R11 R12
  assign done_next = ~no_hs && (state_next == HSC_ST_FIN); // R6 R17
  assign ready_next = ~no_hs && run_last; // R8 R9 R10
  // result loads once per finish and stays put while finish is held
  assign result_next = (HAS_RESULT && run_last) ? sum : result_reg; // R7 R14

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      state_reg <= HSC_ST_IDLE;
      cnt_reg <= CNT_ZERO;
      pend_reg <= HSC_PEND_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      idle_reg <= (CTRL_MODE != HSC_MODE_NONE) && HSC_IDLE_RST; // R23
      ready_reg <= HSC_READY_RST; // R23
      done_reg <= HSC_DONE_RST; // R23
      result_reg <= '0;
    end else begin
      idle_reg <= idle_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      result_reg <= result_next;
    end
  end

  assign O_QUIESCENT_FLAG = idle_reg;
  assign O_ACCEPT_NEXT_FLAG = ready_reg;
  assign O_FINISH_FLAG = done_reg;
  assign O_RESULT_VALUE = result_reg;

  // checks
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_SRST);

  logic [DATA_W-1:0] expect_reg;
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      expect_reg <= '0;
    end else if (launch) begin
      expect_reg <= I_STEADY_CONFIG + DATA_W'(LATENCY) * I_OPERAND;
    end
  end

  // run cycles since the last idle or finish sample, and the request
  // level seen at accept-next, for the timing checks below
  logic [CNT_W:0] busy_cnt_reg;
  logic seen_req_reg;
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST || no_hs || O_QUIESCENT_FLAG || O_FINISH_FLAG) begin
      busy_cnt_reg <= '0;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      seen_req_reg <= 1'b0;
    end else if (O_ACCEPT_NEXT_FLAG) begin
      seen_req_reg <= I_LAUNCH_REQUEST;
    end
  end

  a_wait_start: assert property ( // R1
    (!no_hs && O_QUIESCENT_FLAG && !I_LAUNCH_REQUEST)
    |=> O_QUIESCENT_FLAG && !O_FINISH_FLAG)
    else $error("block left idle without a launch request");

  a_idle_drops: assert property ( // R2
    (!no_hs && O_QUIESCENT_FLAG && I_LAUNCH_REQUEST) |=> !O_QUIESCENT_FLAG)
    else $error("quiescent flag did not drop at launch");

  a_next_starts: assert property ( // R4
    (O_ACCEPT_NEXT_FLAG && I_LAUNCH_REQUEST && go)
    |=> (!O_FINISH_FLAG && !O_QUIESCENT_FLAG) ##1 !O_QUIESCENT_FLAG)
    else $error("next transaction did not start at once");

  a_finish_time: assert property ( // R6
    (!no_hs && O_QUIESCENT_FLAG && I_LAUNCH_REQUEST)
    |-> ##LATENCY (!O_FINISH_FLAG && !O_QUIESCENT_FLAG) ##1 O_FINISH_FLAG)
    else $error("finish flag not raised after the operation");

  a_result_valid: assert property ( // R7
    (HAS_RESULT && O_FINISH_FLAG) |-> O_RESULT_VALUE == expect_reg)
    else $error("result wrong while finish flag high");

  a_ready_gated: assert property ( // R8
    O_QUIESCENT_FLAG |=> !O_ACCEPT_NEXT_FLAG)
    else $error("accept-next raised before a transaction started");

  a_ready_done: assert property ( // R9
    O_ACCEPT_NEXT_FLAG |-> O_FINISH_FLAG && !$past(O_FINISH_FLAG))
    else $error("accept-next not paired with finish");

  a_halt_idle: assert property ( // R11
    (O_ACCEPT_NEXT_FLAG && !I_LAUNCH_REQUEST && go)
    |-> !O_QUIESCENT_FLAG ##1 O_QUIESCENT_FLAG && !O_FINISH_FLAG)
    else $error("quiescent flag not high one cycle after finish");

  a_busy_low: assert property ( // R12
    (O_ACCEPT_NEXT_FLAG && I_LAUNCH_REQUEST) |=> !O_QUIESCENT_FLAG)
    else $error("quiescent flag rose while continuing");

  a_no_ports: assert property ( // R13
    no_hs |-> !O_QUIESCENT_FLAG && !O_FINISH_FLAG && !O_ACCEPT_NEXT_FLAG)
    else $error("control flag active in no-handshake variant");

  a_no_result: assert property ( // R14
    !HAS_RESULT |-> O_RESULT_VALUE == '0)
    else $error("result port active without a return value");

  a_proceed_go: assert property ( // R16
    (O_FINISH_FLAG && I_DOWNSTREAM_PROCEED) |=> !O_FINISH_FLAG)
    else $error("finish flag held although proceed was high");

  a_chain_hold: assert property ( // R17
    (chain && O_FINISH_FLAG && !I_DOWNSTREAM_PROCEED)
    |=> O_FINISH_FLAG && $stable(O_RESULT_VALUE) && !O_ACCEPT_NEXT_FLAG)
    else $error("finish or result not held under back-pressure");

  a_reset_flags: assert property ( // R23
    (!no_hs && $past(I_SRST)) |-> O_QUIESCENT_FLAG && !O_FINISH_FLAG)
    else $error("flags wrong after reset");

  a_reset_outputs: assert property ( // R23
    $past(I_SRST) |-> !O_ACCEPT_NEXT_FLAG && O_RESULT_VALUE == '0)
    else $error("accept-next or result not cleared by reset");

  // flag pairing, counted from the registered outputs, not the state
  a_ready_pulse: assert property ( // R9
    O_ACCEPT_NEXT_FLAG |=> !O_ACCEPT_NEXT_FLAG)
    else $error("accept-next held longer than one cycle");

  a_done_with_ready: assert property ( // R9 R10
    $rose(O_FINISH_FLAG) |-> O_ACCEPT_NEXT_FLAG)
    else $error("finish rose without accept-next");

  a_idle_exclusive: assert property ( // R2 R12
    O_QUIESCENT_FLAG |-> !O_FINISH_FLAG && !O_ACCEPT_NEXT_FLAG)
    else $error("quiescent flag high together with finish or accept-next");

  a_launch_ignored: assert property ( // R2
    (!no_hs && !O_QUIESCENT_FLAG && !O_FINISH_FLAG)
    |=> !O_QUIESCENT_FLAG)
    else $error("block went idle in the middle of a transaction");

  a_idle_after_done: assert property ( // R11
    $rose(O_QUIESCENT_FLAG) |-> $past(O_FINISH_FLAG))
    else $error("quiescent flag rose without a preceding finish");

  // a stuck run shows up here long before the counter could wrap
  a_run_length: assert property ( // R6
    (!no_hs && $rose(O_FINISH_FLAG)) |-> busy_cnt_reg == LATENCY)
    else $error("operation length differs from the configured latency");

  a_busy_bound: assert property ( // R6
    !no_hs |-> busy_cnt_reg <= LATENCY)
    else $error("block busy too long without a finish");

  a_result_steady: assert property ( // R7 R17
    (!no_hs && !$rose(O_FINISH_FLAG)) |-> $stable(O_RESULT_VALUE))
    else $error("result changed outside a finish");

  a_stall_halt: assert property ( // R5 R17
    (chain && O_FINISH_FLAG && !O_ACCEPT_NEXT_FLAG && I_DOWNSTREAM_PROCEED
    && !seen_req_reg) |=> O_QUIESCENT_FLAG && !O_FINISH_FLAG)
    else $error("block did not halt after the stalled finish");

  a_basic_pulse: assert property ( // R6 R16
    (!chain && O_FINISH_FLAG) |=> !O_FINISH_FLAG)
    else $error("finish held in a variant without proceed input");

  c_single: cover property (
    O_QUIESCENT_FLAG && I_LAUNCH_REQUEST ##[1:40] O_QUIESCENT_FLAG);

  c_back_to_back: cover property (
    O_ACCEPT_NEXT_FLAG && I_LAUNCH_REQUEST ##[1:40] O_ACCEPT_NEXT_FLAG);

  c_chain_stall: cover property (
    (chain && O_FINISH_FLAG && !I_DOWNSTREAM_PROCEED) [*3]);

  c_stall_resume: cover property (
    O_FINISH_FLAG && !I_DOWNSTREAM_PROCEED ##1 O_FINISH_FLAG
    && I_DOWNSTREAM_PROCEED ##1 !O_FINISH_FLAG && !O_QUIESCENT_FLAG);

  c_stall_halt: cover property (
    chain && O_FINISH_FLAG && !O_ACCEPT_NEXT_FLAG ##1 O_QUIESCENT_FLAG);

endmodule // hsc_block

// ---- testbench/hsc_far_end.sv ----
// Purpose: downstream consumer model driving the proceed input
// Assumes: finish flag registered on the rising clock edge
// Notes: stalls for i_stall cycles on every finish, then proceeds
`timescale 1ns/1ps
module hsc_far_end (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // handshake
  input wire logic i_finish,
  input wire logic [7:0] i_stall,
  output logic o_proceed
);
  logic [7:0] hold_cnt;

  // proceed low while the consumer cannot take data yet
  always @(negedge i_clk) begin
    if (i_srst) begin
      hold_cnt <= 8'h00;
      o_proceed <= 1'b1;
    end else if (i_finish && hold_cnt < i_stall) begin
      hold_cnt <= hold_cnt + 8'h01;
      o_proceed <= 1'b0;
    end else begin
      o_proceed <= 1'b1;
      if (!i_finish) hold_cnt <= 8'h00;
    end
  end
endmodule // hsc_far_end

// ---- testbench/tb_hsc_block.sv ----
// Purpose: self-checking bench of the start/done handshake block
// Assumes: chained variant, consumer model on the proceed input
// Notes: a second instance checks the no-handshake variant
`timescale 1ns/1ps
module tb_hsc_block;
  import hsc_pkg::*;
  localparam int LAT = 3;
  logic clk, srst, launch, proceed, idle, ready, fin, idle0, ready0, fin0;
  logic idle1, ready1, fin1;
  logic [15:0] op, cfg, res, keep, res0, res1;
  logic [7:0] stall;
  int n_errors = 0;
  int checks = 0;
  int n;

  hsc_block #(.CTRL_MODE(HSC_MODE_CHAIN), .LATENCY(LAT)) i_hsc_block (
    .I_REF_CLK(clk), .I_SRST(srst), .I_LAUNCH_REQUEST(launch),
    .I_DOWNSTREAM_PROCEED(proceed), .O_QUIESCENT_FLAG(idle),
    .O_ACCEPT_NEXT_FLAG(ready), .O_FINISH_FLAG(fin), .I_OPERAND(op),
    .I_STEADY_CONFIG(cfg), .O_RESULT_VALUE(res));
  hsc_block #(.CTRL_MODE(HSC_MODE_NONE), .HAS_RESULT(1'b0), .LATENCY(LAT))
    i_hsc_block_none (
    .I_REF_CLK(clk), .I_SRST(srst), .I_LAUNCH_REQUEST(launch),
    .I_DOWNSTREAM_PROCEED(proceed), .O_QUIESCENT_FLAG(idle0),
    .O_ACCEPT_NEXT_FLAG(ready0), .O_FINISH_FLAG(fin0), .I_OPERAND(op),
    .I_STEADY_CONFIG(cfg), .O_RESULT_VALUE(res0));
  // basic variant shares the proceed net, which it must ignore
  hsc_block #(.CTRL_MODE(HSC_MODE_BASIC), .LATENCY(LAT)) i_hsc_block_basic (
    .I_REF_CLK(clk), .I_SRST(srst), .I_LAUNCH_REQUEST(launch),
    .I_DOWNSTREAM_PROCEED(proceed), .O_QUIESCENT_FLAG(idle1),
    .O_ACCEPT_NEXT_FLAG(ready1), .O_FINISH_FLAG(fin1), .I_OPERAND(op),
    .I_STEADY_CONFIG(cfg), .O_RESULT_VALUE(res1));
  hsc_far_end i_hsc_far_end (.i_clk(clk), .i_srst(srst), .i_finish(fin),
    .i_stall(stall), .o_proceed(proceed));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic start(input logic [15:0] a, input logic [15:0] c);
    @(negedge clk);
    launch = 1'b1;
    op = a;
    cfg = c;
    @(negedge clk);
    chk(16'(idle), 16'h0000);
  endtask

  // counts cycles until the finish flag, bounded
  task automatic wait_fin();
    n = 0;
    while (fin !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 40) begin
        n_errors++;
        summarize();
      end
    end
    chk(16'(n), 16'(LAT));
    chk(16'(ready), 16'h0001);
  endtask

  task automatic t_reset();
    chk({13'h0, idle, ready, fin}, 16'h0004);
    chk(res, 16'h0000);
    chk({13'h0, idle1, ready1, fin1}, 16'h0004);
    repeat (3) @(negedge clk);
    chk({13'h0, idle, ready, fin}, 16'h0004);
    $display("test reset done");
  endtask

  task automatic t_single();
    start(16'h0012, 16'h0100);
    wait_fin();
    chk(res, 16'(16'h0100 + LAT * 16'h0012));
    chk(res1, 16'(16'h0100 + LAT * 16'h0012));
    chk({13'h0, idle0, ready0, fin0}, 16'h0000);
    chk(res0, 16'h0000);
    launch = 1'b0;
    @(negedge clk);
    chk({13'h0, idle, ready, fin}, 16'h0004);
    chk({13'h0, idle1, ready1, fin1}, 16'h0004);
    $display("test single done");
  endtask

  task automatic t_b2b();
    start(16'h0003, 16'hFFF0);
    wait_fin();
    chk(res, 16'(16'hFFF0 + LAT * 16'h0003));
    op = 16'h0101;
    @(negedge clk);
    chk(16'(idle), 16'h0000);
    wait_fin();
    chk(res, 16'(16'hFFF0 + LAT * 16'h0101));
    launch = 1'b0;
    @(negedge clk);
    chk(16'(idle), 16'h0001);
    $display("test back_to_back done");
  endtask

  task automatic t_stall();
    stall = 8'h03;
    start(16'h0007, 16'h0020);
    wait_fin();
    chk(res, 16'(16'h0020 + LAT * 16'h0007));
    launch = 1'b0;
    keep = res;
    repeat (3) begin
      @(negedge clk);
      chk({13'h0, idle, ready, fin}, 16'h0001);
      chk(res, keep);
      chk({13'h0, idle1, ready1, fin1}, 16'h0004);
    end
    @(negedge clk);
    chk({13'h0, idle, ready, fin}, 16'h0004);
    stall = 8'h00;
    $display("test stall done");
  endtask

  initial begin
    srst = 1'b1;
    launch = 1'b0;
    op = 16'h0000;
    cfg = 16'h0000;
    stall = 8'h00;
    repeat (16) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    t_reset();
    t_single();
    t_b2b();
    t_stall();
    summarize();
  end
endmodule // tb_hsc_block
